// ===== rct_top.sv
// Functional notes
// - A watchdog time-out in normal or halt mode with the reset option at 1 issues a full system reset.
// - The watchdog reset option comes up at its unprogrammed value, which enables the reset.
// - A watchdog-caused system reset sets the watchdog flag in the reset cause register.
// - The power-on flag, bit 7, reads 1 after a power-on reset.
// - The power-on flag clears on a watchdog time-out or a pin-change wake from stop.
// - A read of the reset cause register clears the four cause flags.
// - The stop-recovery flag, bit 6, is set by a pin-change wake or a watchdog time-out in stop mode; the watchdog flag tells its source.
// - The stop-recovery flag clears on power-on reset and on a watchdog time-out outside stop mode.
// - The watchdog flag, bit 5, sets on a time-out and clears on power-on reset and pin-change wake.
// - The pin flag, bit 4, sets on a pin reset and clears on power-on reset and pin-change wake.
// - The brown-out-in-sleep option decides whether the brown-out detector runs in stop mode.
// - A brown-out reset sets the power-on flag.
// - A debugger reset or a debug-pin wake from stop reads exactly as a power-on event.
module rct_top
  import rct_pkg::*;
(
  input  wire logic        pclk,          // System clock, 50 MHz.
  input  wire logic        presetn,       // Power-on reset, active low.
  input  wire logic        psel,          // APB select.
  input  wire logic        penable,       // APB enable.
  input  wire logic        pwrite,        // APB direction.
  input  wire logic [11:0] paddr,         // APB byte address.
  input  wire logic [31:0] pwdata,        // APB write data.
  output logic      [31:0] prdata,        // APB read data.
  output logic             pready,        // APB ready.
  output logic             pslverr,       // APB error.
  input  wire rct_pkg::rct_evt_t evt,     // Event pulses and mode levels.
  input  wire logic        reset_pin_n,   // External reset pin, active low.
  output logic             sys_reset,     // System reset request, active high.
  output logic             brownout_en,   // Brown-out detector enable.
  output logic             irq            // Level interrupt.
);

  import rct_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin path.

  logic pin_sync;
  logic pin_assert;
  logic err_r;

  rct_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (reset_pin_n),
    .q       (pin_sync)
  );

  rct_pin_filter u_filt (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_n    (pin_sync),
    .assert_p (pin_assert)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State.

  rct_state_t st_r;
  rct_state_t st_nxt;

  logic setup;
  logic rd_access;
  logic wr_access;
  logic mapped;
  logic wd_reset;
  logic wd_wake;
  logic dbg_por;
  logic pin_chg_wake;
  logic [RCT_EV_N-1:0] ev_vec;

  assign setup     = psel && !penable;
  assign rd_access = psel && penable && !pwrite;
  assign wr_access = psel && penable && pwrite;
  assign mapped    = (paddr == RCT_ADDR_STATUS) || (paddr == RCT_ADDR_OPTION) ||
                     (paddr == RCT_ADDR_IRQ_STATUS) || (paddr == RCT_ADDR_IRQ_ENABLE) ||
                     (paddr == RCT_ADDR_IRQ_CLEAR);

  assign wd_reset     = evt.wdog_timeout && !evt.stop_mode && st_r.option[RCT_OPT_WDOG_RES];
  assign wd_wake      = evt.wdog_timeout && evt.stop_mode;
  assign dbg_por      = evt.debug_reset || (evt.debug_pin_low && evt.stop_mode);
  assign pin_chg_wake = evt.pin_wake && evt.stop_mode;

  assign ev_vec = {evt.brownout, pin_chg_wake || wd_wake, pin_assert, evt.wdog_timeout};

  always_comb
  begin
    st_nxt = st_r;

    if (rd_access && paddr == RCT_ADDR_STATUS)
      st_nxt.cause[7:4] = 4'h0;

    st_nxt.cause[3:0] = RCT_RSVD_VAL;

    // Events follow the read clear so that a set in the same cycle wins.
    if (pin_chg_wake)
    begin
      st_nxt.cause[RCT_BIT_WDOG] = 1'b0;
      st_nxt.cause[RCT_BIT_PIN]  = 1'b0;
      st_nxt.cause[RCT_BIT_POR]  = 1'b0;
      st_nxt.cause[RCT_BIT_STOP] = 1'b1;
    end
    if (evt.wdog_timeout)
    begin
      st_nxt.cause[RCT_BIT_POR]  = 1'b0;
      st_nxt.cause[RCT_BIT_WDOG] = 1'b1;
      st_nxt.cause[RCT_BIT_STOP] = evt.stop_mode;
    end
    if (pin_assert)
      st_nxt.cause[RCT_BIT_PIN] = 1'b1;
    if (evt.brownout || dbg_por)
      st_nxt.cause = RCT_CAUSE_POR_VAL;

    // Options are programmed through the bus; reserved bits are ignored.
    if (wr_access && paddr == RCT_ADDR_OPTION)
      st_nxt.option = pwdata[1:0];
    if (wr_access && paddr == RCT_ADDR_IRQ_ENABLE)
      st_nxt.irq_en = pwdata[RCT_EV_N-1:0];

    // Set wins over the clear register.
    if (wr_access && paddr == RCT_ADDR_IRQ_CLEAR)
      st_nxt.irq_stat = st_nxt.irq_stat & ~pwdata[RCT_EV_N-1:0];
    st_nxt.irq_stat = st_nxt.irq_stat | ev_vec;
    st_nxt.irq      = |(st_nxt.irq_stat & st_nxt.irq_en);

    if (wd_reset || pin_assert || evt.brownout || dbg_por)
      st_nxt.rst_cnt = RCT_RST_PULSE;
    else if (st_r.rst_cnt != 4'h0)
      st_nxt.rst_cnt = st_r.rst_cnt - 4'h1;
    st_nxt.sys_rst = (st_nxt.rst_cnt != 4'h0);

    st_nxt.bo_enable = !evt.stop_mode || st_nxt.option[RCT_OPT_BO_SLEEP];

    // Zero wait state slave: ready is raised in the setup cycle's successor.
    st_nxt.pready = setup;
    st_nxt.prdata = 32'h0;
    if (setup && !pwrite)
    begin
      unique case (paddr)
        RCT_ADDR_STATUS:     st_nxt.prdata = {24'h0, st_nxt.cause[7:4], RCT_RSVD_VAL};
        RCT_ADDR_OPTION:     st_nxt.prdata = {30'h0, st_r.option};
        RCT_ADDR_IRQ_STATUS: st_nxt.prdata = {28'h0, st_r.irq_stat};
        RCT_ADDR_IRQ_ENABLE: st_nxt.prdata = {28'h0, st_r.irq_en};
        default:             st_nxt.prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= '{cause: RCT_CAUSE_POR_VAL, option: RCT_OPT_RESET_VAL, irq_stat: '0,
                irq_en: '0, rst_cnt: 4'h0, sys_rst: 1'b0, bo_enable: 1'b1,
                irq: 1'b0, pready: 1'b0, prdata: 32'h0};
      err_r <= 1'b0;
    end
    else
    begin
      st_r  <= st_nxt;
      err_r <= setup && !mapped;
    end
  end

  assign prdata      = st_r.prdata;
  assign pready      = st_r.pready;
  assign pslverr     = err_r;
  assign sys_reset   = st_r.sys_rst;
  assign brownout_en = st_r.bo_enable;
  assign irq         = st_r.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_rd_status;
    rd_access && paddr == RCT_ADDR_STATUS;
  endsequence

  sequence s_no_event;
    !evt.wdog_timeout && !pin_assert && !evt.brownout && !dbg_por && !pin_chg_wake;
  endsequence

  a_wdog_reset_issue: assert property (@(posedge pclk) disable iff (!presetn)
    wd_reset |=> sys_reset [*8]) else $error("watchdog reset not issued");
  a_option_default: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> st_r.option == RCT_OPT_RESET_VAL) else $error("option default wrong");
  a_wdog_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    evt.wdog_timeout && !evt.brownout && !dbg_por |=> st_r.cause[RCT_BIT_WDOG])
    else $error("watchdog flag not set");
  a_por_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (evt.wdog_timeout || pin_chg_wake) && !evt.brownout && !dbg_por |=> !st_r.cause[RCT_BIT_POR])
    else $error("power-on flag not cleared");
  a_read_clears: assert property (@(posedge pclk) disable iff (!presetn)
    s_rd_status ##0 s_no_event |=> st_r.cause == 8'h00) else $error("read did not clear");
  a_stop_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    pin_chg_wake && !evt.brownout && !dbg_por |=> st_r.cause[7:4] == 4'h4)
    else $error("stop flag wrong");
  a_stop_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    evt.wdog_timeout && !evt.stop_mode && !dbg_por && !evt.brownout |=> !st_r.cause[RCT_BIT_STOP])
    else $error("stop flag not cleared");
  a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.cause[3:0] == 4'h0) else $error("reserved bits nonzero");
  a_bo_sleep: assert property (@(posedge pclk) disable iff (!presetn)
    evt.stop_mode && !st_r.option[RCT_OPT_BO_SLEEP] && !(wr_access && paddr == RCT_ADDR_OPTION)
    |=> !brownout_en) else $error("brown-out enable wrong");
  a_por_report: assert property (@(posedge pclk) disable iff (!presetn)
    evt.brownout || dbg_por |=> st_r.cause == RCT_CAUSE_POR_VAL) else $error("power-on report wrong");
  a_pin_filter: assert property (@(posedge pclk) disable iff (!presetn)
    pin_assert |-> $past(pin_sync, 1) == 1'b0 && $past(pin_sync, 4) == 1'b0)
    else $error("pin accepted too early");

  ////////////////////////////////////////////////////////////////////////////
  // Helper terms for the checks below; they decode the bus, the reset sources and sys_reset and hold no state.

  logic opt_wr;
  logic en_wr;
  logic clr_wr;
  logic st_rd;

  assign opt_wr = wr_access && paddr == RCT_ADDR_OPTION;
  assign en_wr  = wr_access && paddr == RCT_ADDR_IRQ_ENABLE;
  assign clr_wr = wr_access && paddr == RCT_ADDR_IRQ_CLEAR;
  assign st_rd  = rd_access && paddr == RCT_ADDR_STATUS;

  sequence s_quiet_src;
    !wd_reset && !pin_assert && !evt.brownout && !dbg_por;
  endsequence

  sequence s_reset_hold;
    sys_reset [*8];
  endsequence

  sequence s_status_setup;
    psel && !penable && !pwrite && paddr == RCT_ADDR_STATUS;
  endsequence

  // Cause flags.
  a_por_after_reset: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> st_r.cause == RCT_CAUSE_POR_VAL)
    else $error("power-on flag missing after reset");
  a_wdog_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    pin_chg_wake && !evt.wdog_timeout && !evt.brownout && !dbg_por |=> !st_r.cause[RCT_BIT_WDOG])
    else $error("watchdog flag not cleared by pin wake");
  a_pin_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    pin_assert && !evt.brownout && !dbg_por |=> st_r.cause[RCT_BIT_PIN])
    else $error("pin flag not set");
  a_pin_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    pin_chg_wake && !pin_assert && !evt.brownout && !dbg_por |=> !st_r.cause[RCT_BIT_PIN])
    else $error("pin flag not cleared by pin wake");
  a_brownout_por: assert property (@(posedge pclk) disable iff (!presetn)
    evt.brownout |=> st_r.cause[RCT_BIT_POR])
    else $error("brown-out did not set power-on flag");
  a_wdog_wake_flags: assert property (@(posedge pclk) disable iff (!presetn)
    wd_wake && !evt.brownout && !dbg_por |=> st_r.cause[RCT_BIT_STOP] && st_r.cause[RCT_BIT_WDOG])
    else $error("watchdog wake flags wrong");
  a_cause_hold: assert property (@(posedge pclk) disable iff (!presetn)
    s_no_event ##0 !st_rd |=> $stable(st_r.cause))
    else $error("cause changed without event or read");

  // Reset request. Retriggering only lengthens the pulse, so a second cause never shortens it.
  a_wdog_halt_reset: assert property (@(posedge pclk) disable iff (!presetn)
    evt.wdog_timeout && evt.halt_mode && !evt.stop_mode && st_r.option[RCT_OPT_WDOG_RES] |=> s_reset_hold)
    else $error("watchdog reset missing in halt");
  a_wdog_opt_off: assert property (@(posedge pclk) disable iff (!presetn)
    evt.wdog_timeout && !st_r.option[RCT_OPT_WDOG_RES] && st_r.rst_cnt == 4'h0 ##0 s_quiet_src |=> !sys_reset)
    else $error("watchdog reset with option off");
  a_no_spurious_reset: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.rst_cnt == 4'h0 ##0 s_quiet_src |=> !sys_reset)
    else $error("reset without a cause");
  a_reset_length: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.rst_cnt == 4'h1 ##0 s_quiet_src |=> !sys_reset)
    else $error("reset pulse too long");
  a_pin_reset_issue: assert property (@(posedge pclk) disable iff (!presetn)
    pin_assert |=> s_reset_hold)
    else $error("pin reset not issued");
  a_pin_one_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pin_assert |=> !pin_assert)
    else $error("pin accepted twice");

  // Options and the brown-out enable.
  a_option_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !opt_wr |=> $stable(st_r.option))
    else $error("option changed without a write");
  a_bo_awake: assert property (@(posedge pclk) disable iff (!presetn)
    !evt.stop_mode |=> brownout_en)
    else $error("brown-out detector off while awake");
  a_bo_sleep_on: assert property (@(posedge pclk) disable iff (!presetn)
    evt.stop_mode && st_r.option[RCT_OPT_BO_SLEEP] && !opt_wr |=> brownout_en)
    else $error("brown-out detector off in sleep");

  // Bus handshake: zero wait states, and an error only for a hole in the map.
  a_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready)
    else $error("ready missing in access cycle");
  a_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !mapped |=> pslverr && pready)
    else $error("error missing for unmapped address");
  a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && mapped |=> !pslverr)
    else $error("error on a mapped address");
  a_status_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    s_status_setup |=> prdata[3:0] == RCT_RSVD_VAL)
    else $error("reserved bits read nonzero");

  // Interrupt: sticky status bits, masked by the enable register.
  a_irq_raise: assert property (@(posedge pclk) disable iff (!presetn)
    evt.wdog_timeout && st_r.irq_en[RCT_EV_WDOG] && !en_wr |=> irq)
    else $error("interrupt not raised");
  a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.irq_en == '0 && !en_wr |=> !irq)
    else $error("masked interrupt raised");
  a_irq_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    st_r.irq_stat[RCT_EV_WDOG] && !clr_wr |=> st_r.irq_stat[RCT_EV_WDOG])
    else $error("interrupt status lost");
  a_irq_clear: assert property (@(posedge pclk) disable iff (!presetn)
    clr_wr && pwdata[RCT_EV_WDOG] && !evt.wdog_timeout |=> !st_r.irq_stat[RCT_EV_WDOG])
    else $error("interrupt status not cleared");
  a_pin_irq: assert property (@(posedge pclk) disable iff (!presetn)
    pin_assert |=> st_r.irq_stat[RCT_EV_PIN])
    else $error("pin event not recorded");

endmodule

// ===== rct_pkg.sv
package rct_pkg;

  // APB register map.
  localparam logic [11:0] RCT_ADDR_STATUS     = 12'h000;
  localparam logic [11:0] RCT_ADDR_OPTION     = 12'h004;
  localparam logic [11:0] RCT_ADDR_IRQ_STATUS = 12'h008;
  localparam logic [11:0] RCT_ADDR_IRQ_ENABLE = 12'h00c;
  localparam logic [11:0] RCT_ADDR_IRQ_CLEAR  = 12'h010;

  // Reset cause register fields.
  localparam int RCT_BIT_POR  = 7;
  localparam int RCT_BIT_STOP = 6;
  localparam int RCT_BIT_WDOG = 5;
  localparam int RCT_BIT_PIN  = 4;
  localparam logic [7:0] RCT_CAUSE_POR_VAL = 8'h80;
  localparam logic [3:0] RCT_RSVD_VAL      = 4'h0;

  // Option register fields and their unprogrammed values.
  localparam int         RCT_OPT_WDOG_RES  = 0;
  localparam int         RCT_OPT_BO_SLEEP  = 1;
  localparam logic [1:0] RCT_OPT_RESET_VAL = 2'h3;

  // Interrupt event bits.
  localparam int RCT_EV_WDOG = 0;
  localparam int RCT_EV_PIN  = 1;
  localparam int RCT_EV_STOP = 2;
  localparam int RCT_EV_BO   = 3;
  localparam int RCT_EV_N    = 4;

  // Pin filter length and length of the generated system reset pulse.
  localparam int         RCT_FILT_LEN   = 4;
  localparam logic [3:0] RCT_RST_PULSE  = 4'h8;

  typedef struct packed {
    logic wdog_timeout;
    logic brownout;
    logic debug_reset;
    logic debug_pin_low;
    logic stop_mode;
    logic halt_mode;
    logic pin_wake;
  } rct_evt_t;

  typedef struct packed {
    logic [7:0]          cause;
    logic [1:0]          option;
    logic [RCT_EV_N-1:0] irq_stat;
    logic [RCT_EV_N-1:0] irq_en;
    logic [3:0]          rst_cnt;
    logic                sys_rst;
    logic                bo_enable;
    logic                irq;
    logic                pready;
    logic [31:0]         prdata;
  } rct_state_t;

endpackage

// ===== rct_sync.sv
module rct_sync
  import rct_pkg::*;
(
  input  wire logic pclk,     // System clock.
  input  wire logic presetn,  // Asynchronous reset, active low.
  input  wire logic d,        // Asynchronous level.
  output logic      q         // Synchronised level.
);

  logic meta_r;
  logic sync_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
    end
    else
    begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;

endmodule

// ===== rct_pin_filter.sv
module rct_pin_filter
  import rct_pkg::*;
(
  input  wire logic pclk,       // System clock.
  input  wire logic presetn,    // Asynchronous reset, active low.
  input  wire logic pin_n,      // Synchronised reset pin, active low.
  output logic      assert_p    // One-cycle pulse when a low level is accepted.
);

  logic [RCT_FILT_LEN-1:0] hist_r;
  logic                    held_r;
  logic                    low_now;

  assign low_now = (hist_r == '0);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hist_r   <= '1;
      held_r   <= 1'b0;
      assert_p <= 1'b0;
    end
    else
    begin
      hist_r   <= {hist_r[RCT_FILT_LEN-2:0], pin_n};
      held_r   <= low_now;
      assert_p <= low_now && !held_r;
    end
  end

endmodule

// ===== rct_top_tb.sv
module rct_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rct_pkg::*;

  logic        pclk        = 1'b0;
  logic        presetn     = 1'b0;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [11:0] paddr       = 12'h000;
  logic [31:0] pwdata      = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  rct_evt_t    evt         = '0;
  logic        reset_pin_n = 1'b1;
  logic        sys_reset;
  logic        brownout_en;
  logic        irq;
  int          n_fail      = 0;
  int          n_tests     = 0;
  logic [31:0] rd;
  logic        err;
  logic        sr;

  rct_top DUT (
    .pclk        (pclk),
    .presetn     (presetn),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .evt         (evt),
    .reset_pin_n (reset_pin_n),
    .sys_reset   (sys_reset),
    .brownout_en (brownout_en),
    .irq         (irq)
  );

  always #10 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // The request is held until pready is seen high, so a slow slave is tolerated.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      n_fail++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, err}, 32'h0);
  endtask

  // Event pulses last one cycle; the stop and halt levels are kept as they are.
  task automatic fire(input logic [6:0] m);
    @(posedge pclk);
    evt <= rct_evt_t'(m | (evt & 7'h06));
    @(posedge pclk);
    evt <= rct_evt_t'(evt & 7'h06);
    #1 sr = sys_reset;
  endtask

  task automatic lvl(input logic s, input logic h);
    @(posedge pclk);
    evt.stop_mode <= s;
    evt.halt_mode <= h;
  endtask

  task automatic pin_low(input int n);
    @(posedge pclk);
    reset_pin_n <= 1'b0;
    sr = 1'b0;
    repeat (n)
    begin
      @(posedge pclk);
      sr = sr | sys_reset;
    end
    reset_pin_n <= 1'b1;
    repeat (12) @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #50000;
    n_fail++;
    final_report();
  end

  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(12'h000, 32'h80);
    rdc(12'h000, 32'h0);
    rdc(12'h004, 32'h3);
    apb(1'b1, 12'h000, 32'hf0);
    rdc(12'h000, 32'h0);
    fire(7'h40);
    chk({31'h0, sr}, 32'h1);
    rdc(12'h000, 32'h20);
    lvl(1'b0, 1'b1);
    fire(7'h40);
    chk({31'h0, sr}, 32'h1);
    lvl(1'b0, 1'b0);
    fire(7'h20);
    rdc(12'h000, 32'h80);
    fire(7'h20);
    fire(7'h40);
    rdc(12'h000, 32'h20);
    // Let the previous reset pulse run out before checking that none is issued.
    repeat (8) @(posedge pclk);
    lvl(1'b1, 1'b0);
    fire(7'h40);
    chk({31'h0, sr}, 32'h0);
    rdc(12'h000, 32'h60);
    fire(7'h40);
    fire(7'h01);
    rdc(12'h000, 32'h40);
    fire(7'h01);
    lvl(1'b0, 1'b0);
    fire(7'h40);
    rdc(12'h000, 32'h20);
    fire(7'h40);
    fire(7'h10);
    rdc(12'h000, 32'h80);
    lvl(1'b1, 1'b0);
    fire(7'h08);
    rdc(12'h000, 32'h80);
    repeat (2) @(posedge pclk);
    chk({31'h0, brownout_en}, 32'h1);
    apb(1'b1, 12'h004, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, brownout_en}, 32'h0);
    lvl(1'b0, 1'b0);
    repeat (2) @(posedge pclk);
    chk({31'h0, brownout_en}, 32'h1);
    apb(1'b1, 12'h004, 32'h0);
    rdc(12'h004, 32'h0);
    fire(7'h40);
    chk({31'h0, sr}, 32'h0);
    rdc(12'h000, 32'h20);
    apb(1'b1, 12'h004, 32'h3);
    pin_low(12);
    chk({31'h0, sr}, 32'h1);
    rdc(12'h000, 32'h10);
    pin_low(2);
    rdc(12'h000, 32'h0);
    pin_low(12);
    lvl(1'b1, 1'b0);
    fire(7'h01);
    rdc(12'h000, 32'h40);
    lvl(1'b0, 1'b0);
    // Interrupt path: raise, mask, unmask and clear the watchdog event.
    apb(1'b1, 12'h010, 32'hf);
    apb(1'b1, 12'h00c, 32'h1);
    rdc(12'h00c, 32'h1);
    fire(7'h40);
    chk({31'h0, irq}, 32'h1);
    rdc(12'h008, 32'h1);
    apb(1'b1, 12'h00c, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 12'h00c, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 12'h010, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    rdc(12'h008, 32'h0);
    rdc(12'h010, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    final_report();
  end
endmodule
